/* File: cache_ctrl_ipr_defines.svh */
`ifndef CACHE_CTRL_IPR_DEFINES_SVH
`define CACHE_CTRL_IPR_DEFINES_SVH

// Register addresses, as carried on the command address field
`define ADDR_W 16
`define OFF_TMR_CSR 16'h0018
`define OFF_TMR_RELOAD 16'h0019
`define OFF_TMR_COUNT 16'h001A
`define OFF_DAY_CNT 16'h001B
`define OFF_BIU_CTL 16'h00A0
`define OFF_DIAG_CTL 16'h00A1
`define OFF_ERR_TAG 16'h00A2
`define OFF_BIU_STATUS 16'h00A4
`define OFF_ERR_ADDR 16'h00A6
`define OFF_REFILL_CHECK_SYNDROME 16'h00A8
`define OFF_FILL_ADDR 16'h00AA
`define OFF_SW_CHECK 16'h00AE
`define OFF_HALT_CTL 16'h00B0

// Timer control/status fields
`define CSR_RUN 0
`define CSR_XFER 4
`define CSR_STEP 5
`define CSR_EN 6
`define CSR_PEND 7
`define CSR_MISS 31

// Diagnostic control fields
`define DIAG_TEST_MODE 6
`define DIAG_TEST_STEP 7

// Bus-interface control fields steering the probes
`define BIU_EN 0
`define BIU_FHIT 3
`define BIU_WBYP 10

// Bits owned by the control register; the rest mirror diagnostics
`define BIU_USED_MASK 32'hF000673F
`define BIU_RST 32'h00000400
`define DIAG_RST 32'h00008000
`define CNT_ALL_ONES 32'hFFFFFFFF
`define DATA_ZERO 32'h00000000

`endif

/* File: cache_ctrl_ipr_pkg.sv */
package cache_ctrl_ipr_pkg;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [31:0] data;
   } ipr_cmd_type;

   typedef struct packed {
      logic single_qw;
      logic [63:0] data;
   } ipr_rsp_type;

   typedef struct packed {
      logic workstation_io_map;
      logic [2:0] backup_cache_size;
      logic [12:0] rsvd_hi;
      logic [1:0] io_map;
      logic rsvd_12;
      logic rsvd_11;
      logic write_probe_bypass;
      logic quad_io_read_split;
      logic primary_cache_assoc;
      logic [1:0] rsvd_7_6;
      logic [1:0] backup_cache_speed;
      logic backup_cache_force_hit;
      logic chip_enable_suppress;
      logic ecc_mode;
      logic backup_cache_enable;
   } biu_ctl_type;

   typedef struct packed {
      logic read_probe;
      logic write_probe;
      logic force_hit;
   } probe_ctl_type;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_DRAIN = 1'b1
   } seq_state_type;

endpackage

/* File: cache_ctrl_ipr_timer_block.sv */
`timescale 1ns/1ns
`include "cache_ctrl_ipr_defines.svh"

module cache_ctrl_ipr_timer_block (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Register commands
   input wire logic cmd_valid_in,
   input wire cache_ctrl_ipr_pkg::ipr_cmd_type cmd_in,
   output logic cmd_ready_out,
   // Write queue
   input wire logic wq_empty_in,
   output logic wq_conflict_set_out,
   // Replies
   output logic rsp_valid_out,
   output cache_ctrl_ipr_pkg::ipr_rsp_type rsp_out,
   // Time base strobes
   input wire logic us_tick_in,
   input wire logic hz100_tick_in,
   // Timer interrupt and cache configuration
   output logic timer_irq_out,
   output cache_ctrl_ipr_pkg::biu_ctl_type cache_cfg_out,
   output cache_ctrl_ipr_pkg::probe_ctl_type probe_ctl_out
);
   import cache_ctrl_ipr_pkg::*;

   seq_state_type state_ff;
   ipr_cmd_type cmd_ff;
   logic ready_ff;
   logic conflict_ff;
   logic rsp_valid_ff;
   ipr_rsp_type rsp_ff;
   logic run_ff;
   logic irq_en_ff;
   logic pend_ff;
   logic miss_ff;
   logic [31:0] count_ff;
   logic [31:0] reload_ff;
   logic [31:0] day_ff;
   logic [31:0] biu_ff;
   logic [31:0] diag_ff;
   logic irq_ff;
   probe_ctl_type probe_ff;

   logic accept;
   logic exec;
   logic wr;
   logic [31:0] wd;
   logic wr_csr;
   logic wr_reload;
   logic wr_day;
   logic wr_biu;
   logic wr_diag;
   logic own_hit;
   logic step_pulse;
   logic xfer_pulse;
   logic count_inc;
   logic overflow;
   logic test_step;
   logic [31:0] nxt_rdata;
   logic [31:0] csr_view;

   assign accept = cmd_valid_in && ready_ff && (state_ff == ST_IDLE);
   assign exec = (state_ff == ST_DRAIN) && wq_empty_in;
   assign wr = exec && cmd_ff.write;
   assign wd = cmd_ff.data;
   // Writes to unmapped or behaviour-less addresses decode to nothing
   assign wr_csr = wr && (cmd_ff.addr == `OFF_TMR_CSR);
   assign wr_reload = wr && (cmd_ff.addr == `OFF_TMR_RELOAD);
   assign wr_day = wr && (cmd_ff.addr == `OFF_DAY_CNT);
   assign wr_biu = wr && (cmd_ff.addr == `OFF_BIU_CTL);
   assign wr_diag = wr && (cmd_ff.addr == `OFF_DIAG_CTL);

   always_comb
   begin
      unique case (cmd_ff.addr)
         `OFF_TMR_CSR, `OFF_TMR_RELOAD, `OFF_TMR_COUNT, `OFF_DAY_CNT,
         `OFF_BIU_CTL, `OFF_DIAG_CTL, `OFF_ERR_TAG, `OFF_BIU_STATUS,
         `OFF_ERR_ADDR, `OFF_REFILL_CHECK_SYNDROME, `OFF_FILL_ADDR, `OFF_SW_CHECK,
         `OFF_HALT_CTL: own_hit = 1'b1;
         default: own_hit = 1'b0;
      endcase
   end

   // Step is dropped while running or when paired with transfer
   assign step_pulse = wr_csr && wd[`CSR_STEP] && !run_ff && !wd[`CSR_XFER];
   assign xfer_pulse = wr_csr && wd[`CSR_XFER];
   assign count_inc = (run_ff && us_tick_in) || step_pulse;
   // Transfer wins over a same-cycle increment, so no overflow then
   assign overflow = count_inc && !xfer_pulse && (count_ff == `CNT_ALL_ONES);
   assign test_step = wr_diag && wd[`DIAG_TEST_MODE] && wd[`DIAG_TEST_STEP];

   always_comb
   begin
      csr_view = `DATA_ZERO;
      csr_view[`CSR_MISS] = miss_ff;
      csr_view[`CSR_PEND] = pend_ff;
      csr_view[`CSR_EN] = irq_en_ff;
      csr_view[`CSR_RUN] = run_ff;
   end

   // Write-only and unimplemented addresses answer zero
   always_comb
   begin
      unique case (cmd_ff.addr)
         `OFF_TMR_CSR: nxt_rdata = csr_view;
         `OFF_TMR_COUNT: nxt_rdata = count_ff;
         `OFF_DAY_CNT: nxt_rdata = day_ff;
         `OFF_BIU_CTL: nxt_rdata = ~((biu_ff & `BIU_USED_MASK)
                                   | (diag_ff & ~`BIU_USED_MASK));
         default: nxt_rdata = `DATA_ZERO;
      endcase
   end

   // Command sequencing
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_ff <= ST_IDLE;
         ready_ff <= 1'b1;
         cmd_ff <= '0;
      end
      else
      begin
         unique case (state_ff)
            ST_IDLE:
               if (accept)
               begin
                  cmd_ff <= cmd_in;
                  ready_ff <= 1'b0;
                  state_ff <= ST_DRAIN;
               end
            ST_DRAIN:
               if (exec)
               begin
                  ready_ff <= 1'b1;
                  state_ff <= ST_IDLE;
               end
         endcase
      end
   end

   // Write queue ordering and reply
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         conflict_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_ff <= '0;
      end
      else
      begin
         conflict_ff <= accept && !cmd_in.write;
         rsp_valid_ff <= exec;
         if (exec)
         begin
            rsp_ff.single_qw <= own_hit;
            rsp_ff.data <= {`DATA_ZERO, cmd_ff.write ? `DATA_ZERO : nxt_rdata};
         end
      end
   end

   // Interval timer control and status
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_ff <= 1'b0;
         irq_en_ff <= 1'b0;
         pend_ff <= 1'b0;
         miss_ff <= 1'b0;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (wr_csr)
         begin
            run_ff <= wd[`CSR_RUN];
            irq_en_ff <= wd[`CSR_EN];
         end
         // Hardware set beats a same-cycle write-one clear
         if (overflow)
            pend_ff <= 1'b1;
         else if (wr_csr && wd[`CSR_PEND])
            pend_ff <= 1'b0;
         if (overflow && pend_ff)
            miss_ff <= 1'b1;
         else if (wr_csr && wd[`CSR_MISS])
            miss_ff <= 1'b0;
         irq_ff <= pend_ff && irq_en_ff;
      end
   end

   // Interval counter and reload value
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_ff <= `DATA_ZERO;
         reload_ff <= `DATA_ZERO;
      end
      else
      begin
         if (wr_reload)
            reload_ff <= wd;
         if (xfer_pulse)
            count_ff <= reload_ff;
         else if (overflow)
            count_ff <= reload_ff;
         else if (count_inc)
            count_ff <= count_ff + 32'h00000001;
      end
   end

   // Time-of-day counter; a zero value stays parked until written or advanced by a diagnostic test step
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         day_ff <= `DATA_ZERO;
      else if (wr_day)
         day_ff <= wd;
      else if (test_step || (hz100_tick_in && (day_ff != `DATA_ZERO)))
         day_ff <= day_ff + 32'h00000001;
   end

   // Bus-interface and diagnostic control
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         // Size field has no defined reset; parked at zero
         biu_ff <= `BIU_RST;
         diag_ff <= `DIAG_RST;
      end
      else
      begin
         if (wr_biu)
            biu_ff <= wd;
         if (wr_diag)
            diag_ff <= wd;
      end
   end

   // Probe steering: enable takes precedence over force hit
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         probe_ff <= '0;
      else
      begin
         probe_ff.read_probe <= biu_ff[`BIU_EN] && !biu_ff[`BIU_FHIT];
         probe_ff.write_probe <= biu_ff[`BIU_EN] && !biu_ff[`BIU_FHIT]
                                 && !biu_ff[`BIU_WBYP];
         probe_ff.force_hit <= biu_ff[`BIU_EN] && biu_ff[`BIU_FHIT];
      end
   end

   assign cmd_ready_out = ready_ff;
   assign wq_conflict_set_out = conflict_ff;
   assign rsp_valid_out = rsp_valid_ff;
   assign rsp_out = rsp_ff;
   assign timer_irq_out = irq_ff;
   assign cache_cfg_out = biu_ctl_type'(biu_ff);
   assign probe_ctl_out = probe_ff;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_reply_after_drain: assert property (
      rsp_valid_out |-> $past(wq_empty_in) && $past(state_ff == ST_DRAIN))
      else $error("reply issued before write queue drained");
   a_read_conflict: assert property (
      accept && !cmd_in.write |=> wq_conflict_set_out ##1 !wq_conflict_set_out)
      else $error("read did not mark queue conflicts");
   a_single_quad: assert property (
      rsp_valid_out |-> rsp_out.data[63:32] == `DATA_ZERO)
      else $error("reply wider than one quadword");
   a_drop_unmapped: assert property (
      wr && !own_hit |=> $stable(biu_ff) && $stable(reload_ff)
         && (day_ff == $past(day_ff) + 32'($past(hz100_tick_in && (day_ff != `DATA_ZERO)))))
      else $error("unmapped write changed state");
   a_missed_ovf: assert property (
      overflow && pend_ff |=> miss_ff && pend_ff)
      else $error("missed overflow not flagged");
   a_pend_irq: assert property (
      overflow && irq_en_ff && !wr_csr |=> pend_ff ##1 timer_irq_out)
      else $error("overflow did not raise interrupt");
   a_enable_irq: assert property (
      wr_csr && wd[`CSR_EN] && pend_ff && !wd[`CSR_PEND] |-> ##2 timer_irq_out)
      else $error("late enable did not raise interrupt");
   a_step_inc: assert property (
      step_pulse && !overflow |=> count_ff == $past(count_ff) + 32'h00000001)
      else $error("single step did not increment");
   a_xfer_load: assert property (
      xfer_pulse |=> count_ff == $past(reload_ff))
      else $error("transfer did not load count");
   a_stopped_hold: assert property (
      !run_ff && !wr_csr |=> $stable(count_ff))
      else $error("count moved while stopped");
   a_wrap_reload: assert property (
      overflow |=> count_ff == $past(reload_ff) && pend_ff)
      else $error("count did not wrap to reload");
   a_day_parked: assert property (
      day_ff == `DATA_ZERO && !wr_day && !test_step |=> day_ff == `DATA_ZERO)
      else $error("zero day counter advanced");
   a_probe_force: assert property (
      biu_ff[`BIU_EN] && biu_ff[`BIU_FHIT]
         |=> probe_ctl_out.force_hit && !probe_ctl_out.read_probe)
      else $error("force hit not applied");
   a_write_no_conflict: assert property (
      accept && cmd_in.write |=> !wq_conflict_set_out)
      else $error("write marked queue conflicts");
   a_wait_drain: assert property (
      (state_ff == ST_DRAIN) && !wq_empty_in |=> !rsp_valid_out)
      else $error("reply issued with queue busy");
   a_rsp_pulse: assert property (
      rsp_valid_out |=> !rsp_valid_out)
      else $error("reply held longer than one cycle");
   a_pend_clear: assert property (
      wr_csr && wd[`CSR_PEND] && !overflow |=> !pend_ff)
      else $error("pending flag not cleared");
   a_miss_clear: assert property (
      wr_csr && wd[`CSR_MISS] && !(overflow && pend_ff) |=> !miss_ff)
      else $error("missed flag not cleared");
   a_step_running: assert property (
      wr_csr && wd[`CSR_STEP] && !wd[`CSR_XFER] && run_ff && !us_tick_in
         |=> $stable(count_ff))
      else $error("step applied while running");
   a_day_tick: assert property (
      hz100_tick_in && (day_ff != `DATA_ZERO) && !wr_day
         |=> day_ff == $past(day_ff) + 32'h00000001)
      else $error("day counter missed a tick");
   a_test_step: assert property (
      test_step |=> day_ff == $past(day_ff) + 32'h00000001)
      else $error("test step did not advance day counter");
   a_probe_off: assert property (
      !biu_ff[`BIU_EN] |=> !probe_ctl_out.read_probe && !probe_ctl_out.write_probe
         && !probe_ctl_out.force_hit)
      else $error("tag probe while cache disabled");
   a_write_bypass: assert property (
      biu_ff[`BIU_WBYP] |=> !probe_ctl_out.write_probe)
      else $error("write probe despite bypass");
   // Bit 6 is a diagnostic position, so one check covers both halves
   a_ctl_inverted: assert property (
      exec && !cmd_ff.write && (cmd_ff.addr == `OFF_BIU_CTL)
         |=> (rsp_out.data[`BIU_EN] == !$past(biu_ff[`BIU_EN]))
         && (rsp_out.data[`DIAG_TEST_MODE] == !$past(diag_ff[`DIAG_TEST_MODE])))
      else $error("control read not inverted");

   c_force_hit: cover property (probe_ctl_out.force_hit);
   c_overflow: cover property (overflow ##1 timer_irq_out);
   c_read_reply: cover property (accept && !cmd_in.write ##[1:20] rsp_valid_out);
   c_miss: cover property (overflow && pend_ff);
   c_test_step: cover property (test_step);

endmodule

/* File: wq_partner.sv */
`timescale 1ns/1ns

module wq_partner (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Command handshake seen at the block
   input wire logic taken_in,
   input wire logic slow_in,
   // Queue state
   output logic wq_empty_out
);
   logic [2:0] pend_ff;

   // Slow mode: earlier writes still draining when a command lands
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pend_ff <= 3'h0;
      else if (taken_in && slow_in)
         pend_ff <= 3'h5;
      else if (pend_ff != 3'h0)
         pend_ff <= pend_ff - 3'h1;
   end

   assign wq_empty_out = (pend_ff == 3'h0);
endmodule

/* File: cache_ctrl_ipr_timer_block_tb_top.sv */
`timescale 1ns/1ns
`include "cache_ctrl_ipr_defines.svh"

module cache_ctrl_ipr_timer_block_tb_top;
   import cache_ctrl_ipr_pkg::*;
   localparam logic [15:0] UNMAPPED = 16'h0050;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   ipr_cmd_type cmd = '0;
   logic us_tick = 1'b0;
   logic hz_tick = 1'b0;
   logic slow = 1'b0;
   logic cmd_ready, wq_empty, conflict, rsp_valid, irq;
   ipr_rsp_type rsp;
   biu_ctl_type cfg;
   probe_ctl_type probe;
   int fails = 0;
   int compares = 0;
   logic [31:0] diag_v = `DIAG_RST;

   always #2 clk = ~clk;

   cache_ctrl_ipr_timer_block uut (.sys_clk_in(clk), .rst_n_in(rst_n),
      .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
      .wq_empty_in(wq_empty), .wq_conflict_set_out(conflict),
      .rsp_valid_out(rsp_valid), .rsp_out(rsp), .us_tick_in(us_tick),
      .hz100_tick_in(hz_tick), .timer_irq_out(irq), .cache_cfg_out(cfg),
      .probe_ctl_out(probe));

   wq_partner partner (.clk_in(clk), .rst_n_in(rst_n), .taken_in(cmd_valid && cmd_ready),
      .slow_in(slow), .wq_empty_out(wq_empty));

   task automatic close_out();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] biu_read(input logic [31:0] b);
      return ~((b & `BIU_USED_MASK) | (diag_v & ~`BIU_USED_MASK));
   endfunction

   // One command, held until taken; latency and conflict pulse judged here
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
      output ipr_rsp_type r);
      int lat;
      logic cf;
      lat = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{write: wr, addr: a, data: d};
      @(posedge clk);
      while (cmd_ready !== 1'b1)
         @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      cf = conflict;
      do
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      while (rsp_valid !== 1'b1 && lat < 40);
      r = rsp;
      chk(64'(lat), slow ? 64'h6 : 64'h1);
      chk(64'(cf), 64'(!wr));
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      ipr_rsp_type r;
      acc(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      ipr_rsp_type r;
      acc(1'b0, a, e, r);
      chk(r.data, {32'h0, e});
      chk(64'(r.single_qw), 64'(a != UNMAPPED));
   endtask

   // Single-cycle strobes on the block clock
   task automatic pulse(input logic sel_hz, input int n);
      repeat (n)
      begin
         @(posedge clk);
         if (sel_hz)
            hz_tick <= 1'b1;
         else
            us_tick <= 1'b1;
         @(posedge clk);
         hz_tick <= 1'b0;
         us_tick <= 1'b0;
      end
   endtask

   task automatic t_reset();
      #1;
      chk(64'(cfg), 64'(`BIU_RST));
      chk(64'(cfg.backup_cache_speed), 64'h0);
      chk(64'(probe), 64'h0);
      chk(64'(irq), 64'h0);
      rd(`OFF_TMR_CSR, 32'h0);
      rd(`OFF_TMR_COUNT, 32'h0);
      rd(`OFF_BIU_CTL, biu_read(`BIU_RST));
   endtask

   task automatic t_biu();
      logic [31:0] v;
      logic [31:0] pv [4] = '{32'h0000230F, 32'h00000401, 32'h00000001, 32'h00000008};
      logic [2:0] pe [4] = '{3'b001, 3'b100, 3'b110, 3'b000};
      for (int i = 0; i < 7; i++)
      begin
         v = {1'b0, 3'(i), 28'h0} | {26'h0, 2'(i % 3), 4'h0} | pv[i % 4];
         wr(`OFF_BIU_CTL, v);
         @(posedge clk);
         #1;
         chk(64'(cfg & `BIU_USED_MASK), 64'(v));
         chk(64'(probe), 64'(pe[i % 4]));
         rd(`OFF_BIU_CTL, biu_read(v));
      end
   endtask

   task automatic t_timer();
      wr(`OFF_TMR_RELOAD, 32'h00000010);
      wr(`OFF_TMR_CSR, 32'h00000010);
      rd(`OFF_TMR_COUNT, 32'h00000010);
      wr(`OFF_TMR_CSR, 32'h00000020);
      rd(`OFF_TMR_COUNT, 32'h00000011);
      wr(`OFF_TMR_CSR, 32'h00000030);
      rd(`OFF_TMR_COUNT, 32'h00000010);
      pulse(1'b0, 3);
      rd(`OFF_TMR_COUNT, 32'h00000010);
      rd(`OFF_TMR_CSR, 32'h0);
      wr(`OFF_TMR_RELOAD, 32'hFFFFFFFD);
      wr(`OFF_TMR_CSR, 32'h00000010);
      wr(`OFF_TMR_CSR, 32'h00000001);
      pulse(1'b0, 2);
      rd(`OFF_TMR_COUNT, 32'hFFFFFFFF);
      pulse(1'b0, 1);
      rd(`OFF_TMR_COUNT, 32'hFFFFFFFD);
      rd(`OFF_TMR_CSR, 32'h00000081);
      chk(64'(irq), 64'h0);
      // Step while running must be ignored; later count reads prove it
      wr(`OFF_TMR_CSR, 32'h00000061);
      @(posedge clk);
      #1;
      chk(64'(irq), 64'h1);
      pulse(1'b0, 3);
      rd(`OFF_TMR_CSR, 32'h800000C1);
      wr(`OFF_TMR_CSR, 32'h800000C1);
      rd(`OFF_TMR_CSR, 32'h00000041);
      chk(64'(irq), 64'h0);
      wr(`OFF_TMR_CSR, 32'h0);
   endtask

   task automatic t_day();
      pulse(1'b1, 1);
      rd(`OFF_DAY_CNT, 32'h0);
      wr(`OFF_DAY_CNT, 32'h00000005);
      pulse(1'b1, 2);
      rd(`OFF_DAY_CNT, 32'h00000007);
      wr(`OFF_DIAG_CTL, 32'h000000C0);
      diag_v = 32'h000000C0;
      rd(`OFF_DAY_CNT, 32'h00000008);
      wr(`OFF_DIAG_CTL, 32'h00000040);
      diag_v = 32'h00000040;
      rd(`OFF_DAY_CNT, 32'h00000008);
      rd(`OFF_BIU_CTL, biu_read(32'h60000001));
   endtask

   // Queue still busy on every access: completion must wait for it
   task automatic t_unmapped();
      @(posedge clk);
      slow <= 1'b1;
      wr(UNMAPPED, 32'hFFFFFFFF);
      rd(UNMAPPED, 32'h0);
      wr(`OFF_TMR_COUNT, 32'h00001234);
      rd(`OFF_TMR_COUNT, 32'hFFFFFFFD);
      rd(`OFF_TMR_RELOAD, 32'h0);
      rd(`OFF_TMR_CSR, 32'h0);
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_biu();
      t_timer();
      t_day();
      t_unmapped();
      close_out();
   end

   initial
   begin
      #100000;
      fails++;
      close_out();
   end
endmodule
